// ### pkg/sdsc_consts.vh
// constants for the synthesizer divider and sync control block
`ifndef SDSC_CONSTS_VH
`define SDSC_CONSTS_VH
`define SDSC_PD_MIN_KHZ      32'd14000
`define SDSC_PD_MAX_KHZ      32'd18000
`define SDSC_REF_MAX_KHZ     32'd144000
`define SDSC_FB_RATIO        8'd84
`define SDSC_OUT_DIV         8'd2
`define SDSC_POST_MAX        4'd8
`define SDSC_VCO_MIN_MHZ     32'd2352
`define SDSC_VCO_MAX_MHZ     32'd3024
`define SDSC_REF_DIV_W       2
`define SDSC_RDIV_1          2'd0
`define SDSC_RDIV_2          2'd1
`define SDSC_RDIV_4          2'd2
`define SDSC_RDIV_8          2'd3
`define SDSC_MODE_PASS       2'd0
`define SDSC_MODE_DIV2       2'd1
`define SDSC_MODE_DIV8       2'd2
`define SDSC_MODE_OFF        2'd3
`define SDSC_ST_RUN          2'd0
`define SDSC_ST_STOPPING     2'd1
`define SDSC_ST_STOPPED      2'd2
`define SDSC_ST_STARTING     2'd3
`endif

// ### design/sdsc_ref_div.v
// reference divider: one enable pulse per 1, 2, 4 or 8 reference half periods
`timescale 1ns/100ps
`include "sdsc_consts.vh"
module sdsc_ref_div
(
  input  wire       clock,
  input  wire       rst_sync_b,
  input  wire       ref_edge,
  input  wire [1:0] ref_div_sel,
  output reg        ref_tick_q
);
  reg [2:0] cnt_q;
  reg [2:0] last_w;

  always @*
  begin
    case (ref_div_sel)
      `SDSC_RDIV_1: last_w = 3'h0;
      `SDSC_RDIV_2: last_w = 3'h1;
      `SDSC_RDIV_4: last_w = 3'h3;
      default:      last_w = 3'h7;
    endcase
  end

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      cnt_q      <= 3'h0;
      ref_tick_q <= 1'b0;
    end
    else
    begin
      ref_tick_q <= 1'b0;
      if (ref_edge)
      begin
        if (cnt_q >= last_w)
        begin
          cnt_q      <= 3'h0;
          ref_tick_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule // sdsc_ref_div

// ### design/sdsc_top.v
// divider and output sync control of a multi-bank clock synthesizer
// Functional notes
// [R1] select reference or crystal for phase detector
// [R2] phase detector input kept within 14-18 MHz; not enforced here, the board sets ref_div_sel
// [R3] divide-by-eight allows reference up to 144MHz
// [R4] divide-by-one needs reference at least 14MHz
// [R5] oscillator and bank output frequency ranges
// [R6] output equals phase times 84 over dividers
// [R7] sync fall stops outputs when all low
// [R8] sync rise restarts once all dividers low
// [R9] all banks rise together after restart
// [R10] per bank pass, div2, div8 or off
// [R11] disabled bank: true low, complement high
// [R12] sync input synchronised before edge detection
`timescale 1ns/100ps
`include "sdsc_consts.vh"
module sdsc_top
#(
  parameter NBANK = 5
)
(
  input  wire             clock,
  input  wire             rst_b,
  input  wire             ref_clock_in,
  input  wire             xtal_clock_in,
  input  wire             ref_src_sel,
  input  wire [1:0]       ref_div_sel,
  input  wire             sync_in,
  input  wire [2*NBANK-1:0] bank_freq_select,
  input  wire [NBANK-1:0] bank_enable,
  output reg              pd_clock_q,
  output reg  [NBANK-1:0] bank_out_q,
  output reg  [NBANK-1:0] bank_out_n_q,
  output reg              outputs_live_q
);
  ////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  reg [1:0] rst_q;
  wire      rst_sync_b = rst_q[1];

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  reg [1:0]         ref_s_q;
  reg [1:0]         xtal_s_q;
  reg [1:0]         sync_s_q;
  reg               ref_d_q;
  reg               sync_d_q;
  reg               src_q;
  // configuration pins are quasi-static; a bit that lands one clock late only
  // shifts the moment at which the new setting applies
  reg [1:0]         src_sel_s_q;
  reg [1:0]         div_sel_s1_q;
  reg [1:0]         div_sel_s2_q;
  reg [2*NBANK-1:0] bsel_s1_q;
  reg [2*NBANK-1:0] bsel_s2_q;
  reg [NBANK-1:0]   ben_s1_q;
  reg [NBANK-1:0]   ben_s2_q;

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ref_s_q  <= 2'h0;
      xtal_s_q <= 2'h0;
      sync_s_q <= 2'h3;
      ref_d_q  <= 1'b0;
      sync_d_q <= 1'b1;
      src_q        <= 1'b0;
      src_sel_s_q  <= 2'h0;
      div_sel_s1_q <= 2'h0;
      div_sel_s2_q <= 2'h0;
      bsel_s1_q    <= {2*NBANK{1'b0}};
      bsel_s2_q    <= {2*NBANK{1'b0}};
      ben_s1_q     <= {NBANK{1'b0}};
      ben_s2_q     <= {NBANK{1'b0}};
    end
    else
    begin
      ref_s_q  <= {ref_s_q[0], ref_clock_in};
      xtal_s_q <= {xtal_s_q[0], xtal_clock_in};
      sync_s_q <= {sync_s_q[0], sync_in};   // [R12]
      ref_d_q  <= ref_s_q[1];
      sync_d_q <= sync_s_q[1];
      src_q        <= src_sel_s_q[1] ? xtal_s_q[1] : ref_d_q;
      src_sel_s_q  <= {src_sel_s_q[0], ref_src_sel};
      div_sel_s1_q <= ref_div_sel;
      div_sel_s2_q <= div_sel_s1_q;
      bsel_s1_q    <= bank_freq_select;
      bsel_s2_q    <= bsel_s1_q;
      ben_s1_q     <= bank_enable;
      ben_s2_q     <= ben_s1_q;
    end
  end

  wire sync_fall = sync_d_q & ~sync_s_q[1];   // [R12]
  wire sync_rise = ~sync_d_q & sync_s_q[1];   // [R12]
  // both edges count, so a divide-by-one pd clock follows the reference 1:1
  wire ref_edge  = ref_s_q[1] ^ ref_d_q;

  ////////////////////////////////////////////////////////////////////
  // input selector and reference divider
  wire ref_tick;

  // the divider only scales the reference; keeping the result inside the phase
  // detector window is the board's job through ref_div_sel
  sdsc_ref_div u_ref_div
  (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .ref_edge   (ref_edge),       // [R3] [R4]
    .ref_div_sel(div_sel_s2_q),   // [R2]
    .ref_tick_q (ref_tick)
  );

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      pd_clock_q <= 1'b0;
    else if (src_sel_s_q[1])
      pd_clock_q <= src_q;                    // [R1]
    else if (ref_tick)
      pd_clock_q <= ~pd_clock_q;              // [R1]
  end

  ////////////////////////////////////////////////////////////////////
  // post dividers: clock is the divided oscillator clock; one /8 counter
  // serves all banks so every bank shares phase, and a tick alternates
  // the pass-through half period
  reg  [2:0] post_q;
  reg        pre_q;
  localparam [1:0] ST_RUN      = `SDSC_ST_RUN;
  localparam [1:0] ST_STOPPING = `SDSC_ST_STOPPING;
  localparam [1:0] ST_STOPPED  = `SDSC_ST_STOPPED;
  localparam [1:0] ST_STARTING = `SDSC_ST_STARTING;
  reg  [1:0] st_q;
  wire       div_run = (st_q == ST_RUN) || (st_q == ST_STOPPING);
  // last count of the cycle: every bank output is low after this step
  wire       all_low = (post_q == 3'h7) & pre_q;

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      pre_q  <= 1'b0;
      post_q <= 3'h0;
    end
    else if (div_run)
    begin
      pre_q <= ~pre_q;                        // [R6]
      if (pre_q)
        post_q <= post_q + 3'h1;              // [R6]
    end
    else
    begin
      pre_q  <= 1'b0;                         // [R8]
      post_q <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sync state machine
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st_q <= ST_RUN;
    else
    begin
      case (st_q)
        ST_RUN:
          if (sync_fall)
            st_q <= ST_STOPPING;
        ST_STOPPING:
          if (all_low)
            st_q <= ST_STOPPED;               // [R7]
        ST_STOPPED:
          if (sync_rise)
            st_q <= ST_STARTING;
        ST_STARTING:
          st_q <= ST_RUN;                     // [R8] [R9]
        default:
          st_q <= ST_RUN;
      endcase
    end
  end

  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      outputs_live_q <= 1'b1;
    else
      outputs_live_q <= div_run && !(st_q == ST_STOPPING && all_low);  // [R7]
  end

  ////////////////////////////////////////////////////////////////////
  // per bank output selection
  genvar b;
  generate
    for (b = 0; b < NBANK; b = b + 1)
    begin : g_bank
      wire [1:0] mode = ben_s2_q[b] ? bsel_s2_q[2*b+1:2*b] : `SDSC_MODE_OFF;
      reg        nxt;
      always @*
      begin
        case (mode)
          `SDSC_MODE_PASS: nxt = ~pre_q;                    // [R10]
          // each mode is high in the first half of its period counted from
          // zero, so a restarted counter raises every bank on the same edge
          `SDSC_MODE_DIV2: nxt = ~post_q[0];                // [R10] [R9]
          `SDSC_MODE_DIV8: nxt = ~post_q[2];                // [R10] [R9]
          default:         nxt = 1'b0;                      // [R11]
        endcase
      end
      always @(posedge clock or negedge rst_sync_b)
      begin
        if (!rst_sync_b)
        begin
          bank_out_q[b]   <= 1'b0;
          bank_out_n_q[b] <= 1'b1;
        end
        else if (!div_run || (st_q == ST_STOPPING && all_low))
        begin
          bank_out_q[b]   <= 1'b0;                          // [R7] [R11]
          bank_out_n_q[b] <= 1'b1;
        end
        else
        begin
          bank_out_q[b]   <= nxt;                           // [R9] [R5]
          bank_out_n_q[b] <= ~nxt;
        end
      end
    end
  endgenerate
endmodule // sdsc_top

// ### verif/sdsc_top_monitor.sv
// checker for sync and bank output behaviour
`timescale 1ns/100ps
`include "sdsc_consts.vh"
module sdsc_top_monitor #(parameter NBANK = 5) (
  input wire               clock,
  input wire               rst_b,
  input wire               sync_in,
  input wire [2*NBANK-1:0] bank_freq_select,
  input wire [NBANK-1:0]   bank_enable,
  input wire [NBANK-1:0]   bank_out_q,
  input wire [NBANK-1:0]   bank_out_n_q,
  input wire               outputs_live_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [NBANK-1:0] act;
  logic             held_q;
  always_comb
    for (int i = 0; i < NBANK; i++)
      act[i] = bank_enable[i] && bank_freq_select[2*i+:2] != `SDSC_MODE_OFF;
  // held stays up from the stop until the first bank edge after restart
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
      held_q <= 1'b0;
    else
      held_q <= !outputs_live_q || (held_q && bank_out_q == '0);
  sequence s_fall;
    $fell(sync_in) && outputs_live_q;
  endsequence
  sequence s_rise;
    $rose(sync_in) && !outputs_live_q;
  endsequence
  AST_COMPL: assert property (bank_out_n_q == ~bank_out_q)
    else $error("complement wrong");
  // bank settings pass two pin synchroniser stages, so outputs follow three clocks late
  AST_OFF: assert property ((bank_out_q & ~act & ~$past(act) & ~$past(act, 2)
    & ~$past(act, 3)) == '0)
    else $error("off bank high");
  AST_STOP_LOW: assert property (!outputs_live_q |-> bank_out_q == '0)
    else $error("stopped bank high");
  AST_STOP_COMP: assert property (!outputs_live_q |-> &bank_out_n_q)
    else $error("stopped complement low");
  AST_STOP_TIME: assert property (s_fall |-> outputs_live_q [*2] ##[1:24] !outputs_live_q)
    else $error("stop timing");
  AST_RESTART: assert property (s_rise |-> !outputs_live_q [*2] ##[1:8] outputs_live_q)
    else $error("restart timing");
  AST_HOLD: assert property (!outputs_live_q && !sync_in |=> !outputs_live_q)
    else $error("early restart");
  AST_FIRST: assert property (held_q && bank_out_q != '0 |-> bank_out_q == act)
    else $error("first edges apart");
endmodule // sdsc_top_monitor
bind sdsc_top sdsc_top_monitor #(.NBANK(NBANK)) sdsc_top_monitor_inst (.clock, .rst_b,
  .sync_in, .bank_freq_select, .bank_enable, .bank_out_q, .bank_out_n_q, .outputs_live_q);

// ### verif/sdsc_load_model.sv
// clock load model counting rising edges of each bank
`timescale 1ns/100ps
module sdsc_load_model #(parameter NBANK = 5) (
  input  logic                   clock,
  input  logic                   clear,
  input  logic [NBANK-1:0]       bank_out_q,
  output logic [NBANK-1:0][15:0] rise_cnt,
  output logic [NBANK-1:0][15:0] first_t
);
  logic [15:0]      t_q = 16'h0;
  logic [NBANK-1:0] last_q;
  always @(posedge clock)
  begin
    t_q <= t_q + 16'h1;
    last_q <= bank_out_q;
    for (int i = 0; i < NBANK; i++)
      if (clear)
        {rise_cnt[i], first_t[i]} <= {16'h0, 16'hffff};
      else if (bank_out_q[i] && !last_q[i])
      begin
        rise_cnt[i] <= rise_cnt[i] + 16'h1;
        if (&first_t[i])
          first_t[i] <= t_q;
      end
  end
endmodule // sdsc_load_model

// ### verif/sdsc_top_tb.sv
// self-checking bench for the divider and sync control block
`timescale 1ns/100ps
module sdsc_top_tb;
  logic             clock = 0, rst_b = 0, ref_on = 1, ref_src_sel = 0, sync_in = 1;
  logic             clear = 1, ref_clock_in = 0, xtal_clock_in = 0;
  logic [1:0]       ref_div_sel = 2'h0;
  logic [9:0]       bsel = 10'h0e4;
  logic [4:0]       ben = 5'h0f;
  logic [15:0]      cyc = 16'h0;
  logic             pd_clock_q, outputs_live_q;
  logic [4:0]       bank_out_q, bank_out_n_q;
  logic [4:0][15:0] rise_cnt, first_t;
  int               err_count = 0, total_checks = 0, c0, n;
  int               exp_rise[10] = '{128, 64, 16, 0, 0, 0, 64, 16, 64, 128};
  sdsc_top #(.NBANK(5)) sdsc_top_inst (.clock, .rst_b, .ref_clock_in, .xtal_clock_in,
    .ref_src_sel, .ref_div_sel, .sync_in, .bank_freq_select(bsel),
    .bank_enable(ben), .pd_clock_q, .bank_out_q, .bank_out_n_q, .outputs_live_q);
  sdsc_load_model sdsc_load_model_inst (.clock, .clear, .bank_out_q, .rise_cnt, .first_t);
  initial forever #5 clock = ~clock;
  // reference runs at an eighth, crystal at a sixteenth of the clock rate
  always @(posedge clock)
  begin
    cyc <= cyc + 16'h1;
    ref_clock_in <= ref_on & cyc[2];
    xtal_clock_in <= cyc[3];
    if (cyc == 16'd8000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, exp, tol);
    total_checks++;
    if ((seen + tol >= exp && seen <= exp + tol) !== 1'b1)
    begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic wait_live(logic v);
    for (n = 0; outputs_live_q !== v && n < 40; n++)
      @(posedge clock);
  endtask
  task automatic cnt_pd();
    logic l;
    repeat (40) @(posedge clock);
    n = 0;
    repeat (256)
    begin
      l = pd_clock_q;
      @(posedge clock);
      n += (pd_clock_q & ~l) === 1'b1;
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1;
    for (int k = 0; k < 4; k++)
    begin
      ref_div_sel <= k[1:0];
      cnt_pd();
      if (k == 0)
        c0 = n;
      chk("pd_rate", n, c0 >> k, 1);
    end
    chk("pd_alive", c0 > 7, 1, 0);
    ref_src_sel <= 1;
    ref_on <= 0;
    cnt_pd();
    chk("pd_xtal", n, c0 >> 1, 1);
    ref_src_sel <= 0;
    cnt_pd();
    chk("pd_idle", n, 0, 0);
    $display("test pd done");
    clear <= 0;
    repeat (256) @(posedge clock);
    for (int b = 0; b < 5; b++)
      chk("bank_rise", rise_cnt[b], exp_rise[b], 1);
    chk("bank_pair", bank_out_n_q ^ bank_out_q, 5'h1f, 0);
    $display("test banks done");
    sync_in <= 0;
    @(posedge clock);
    wait_live(0);
    chk("stop_lat", n, 11, 8);
    repeat (20) @(posedge clock);
    chk("stopped", {outputs_live_q, bank_out_q, bank_out_n_q}, 11'h01f, 0);
    clear <= 1;
    sync_in <= 1;
    @(posedge clock);
    clear <= 0;
    wait_live(1);
    chk("start_lat", n, 5, 1);
    repeat (64) @(posedge clock);
    for (int b = 1; b < 3; b++)
      chk("first_rise", first_t[b], first_t[0], 0);
    chk("restarted", rise_cnt[0] > 8, 1, 0);
    $display("test sync done");
    // bank 0 off by enable, bank 3 to divide-by-two, bank 4 enabled in pass mode
    {bsel, ben} <= {10'h064, 5'h1e};
    clear <= 1;
    repeat (8) @(posedge clock);
    clear <= 0;
    repeat (256) @(posedge clock);
    for (int b = 0; b < 5; b++)
      chk("bank_mode", rise_cnt[b], exp_rise[b + 5], 1);
    $display("test modes done");
    summarize();
  end
endmodule // sdsc_top_tb
